// File: hw/aoc_pkg.sv
// constants and types for the output configuration register bank
package aoc_pkg;
  localparam int REG_COUNT = 10;
  localparam int IDX_FORMAT = 0;
  localparam int IDX_PAT_HI = 1;
  localparam int IDX_PAT_LO = 2;
  localparam int IDX_IFACE = 3;
  localparam int IDX_FALL = 4;
  localparam int IDX_POWER = 5;
  localparam int IDX_HF = 6;
  localparam int IDX_PED = 7;
  localparam int IDX_LOOP = 8;
  localparam int IDX_DRIVE = 9;
  // register addresses, entry i belongs to index i
  localparam logic [REG_COUNT-1:0][7:0] REG_OFFSETS = {8'h26, 8'hcf, 8'hbf, 8'h4a,
    8'h43, 8'h42, 8'h41, 8'h40, 8'h3f, 8'h3d};
  // writable bits; reserved bits are dropped and read back as zero
  localparam logic [REG_COUNT-1:0][7:0] REG_MASKS = {8'h03, 8'hbc, 8'hfc, 8'h01,
    8'h53, 8'hcc, 8'hff, 8'hfc, 8'hff, 8'he0};
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int FMT_LSB = 6;
  localparam int LOOP_EN_BIT = 5;
  localparam int IFACE_LSB = 6;
  localparam int CLK_DRIVE_LSB = 4;
  localparam int RISE_EN_BIT = 3;
  localparam int RISE_POS_LSB = 1;
  localparam int FALL_EN_BIT = 0;
  localparam int FALL_POS_LSB = 6;
  localparam int DIG_EN_BIT = 3;
  localparam int SLEEP_BIT = 2;
  localparam int PDN_BIT = 6;
  localparam int OBUF_BIT = 4;
  localparam int SWING_LSB = 0;
  localparam int HF_BIT = 0;
  localparam int PED_LSB = 2;
  localparam int HOLD_BIT = 7;
  localparam int TC_LSB = 2;
  localparam int DCLK_BIT = 1;
  localparam int DDATA_BIT = 0;
  localparam int PAT_LO_LSB = 2;
  // field codes
  localparam logic [1:0] FMT_PIN = 2'h0;
  localparam logic [1:0] FMT_TWOS = 2'h2;
  localparam logic [1:0] FMT_OBIN = 2'h3;
  localparam logic [1:0] IFACE_LVDS = 2'h1;
  localparam logic [1:0] IFACE_CMOS = 2'h3;
  localparam logic [1:0] SWING_ON = 2'h3;
  localparam logic [1:0] EDGE_ALIGN = 2'h2;
  localparam logic [2:0] PATTERN_CUSTOM = 3'h5;
  // correction loop: code 0 is 2^20 sample cycles, doubling up to code 1011
  localparam int TC_BASE_SHIFT = 20;
  localparam logic [3:0] TC_MAX_CODE = 4'hb;
  localparam int SAMPLE_BITS = 14;
  localparam int ACC_BITS = 48;
  localparam logic signed [15:0] MID_CODE = 16'sh2000;
  // output clock edge advance in picoseconds
  localparam int EDGE_PS_BITS = 11;
  localparam logic [10:0] LVDS_RISE_01_PS = 11'd500;
  localparam logic [10:0] LVDS_RISE_11_PS = 11'd200;
  localparam logic [10:0] LVDS_FALL_01_PS = 11'd400;
  localparam logic [10:0] LVDS_FALL_11_PS = 11'd200;
  localparam logic [10:0] CMOS_EDGE_01_PS = 11'd100;
  localparam logic [10:0] CMOS_EDGE_10_PS = 11'd200;
  localparam logic [10:0] CMOS_EDGE_11_PS = 11'd1500;
  localparam logic [3:0] SER_LAST_BIT = 4'h7;
  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_ADDR = 4'b0010,
    SER_DATA = 4'b0100,
    SER_DONE = 4'b1000
  } aoc_ser_state_type;
endpackage

// File: hw/aoc_output_config.sv
// serial register bank and output stage control of the converter
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - format field: pin, twos complement, offset binary
// - format bit 5 enables offset correction
// - custom word: high byte plus low six bits
// - 12-bit variant drops custom bits 1:0
// - interface field: pin, forced LVDS, forced CMOS
// - CMOS clock drive: four strengths, maximum default
// - edge positions apply only when enable set
// - LVDS rise codes: 500ps, aligned, 200ps
// - CMOS rise codes: 100ps, 200ps, 1.5ns
// - LVDS fall codes: 400ps, aligned, 200ps
// - CMOS fall codes: 100ps, 200ps, 1.5ns
// - digital path off bypasses custom pattern and correction; format coding still applies
// - quick sleep stops core and drivers only
// - full powerdown stops everything, slow wake
// - driver off puts outputs high impedance
// - loop converges to mid-code plus pedestal
// - hold freezes estimate, keeps applying it
// - loop period doubles from 1M to 2G
// - drive bits double clock or data drive
// - pattern selector 101 sends custom word
module aoc_output_config #(
  parameter int OUT_BITS = 14
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serEnableN,
  input wire logic serClk,
  input wire logic serDataIn,
  input wire logic readoutEnable,
  output logic serDataOut,
  input wire logic formatSelectPin,
  input wire logic interfaceSelectPin,
  input wire logic [2:0] testPatternSelect,
  input wire logic [aoc_pkg::SAMPLE_BITS-1:0] sampleIn,
  output logic [OUT_BITS-1:0] dataOut,
  output logic outputDriveEnable,
  output logic lvdsMode,
  output logic [1:0] cmosClockDrive,
  output logic [aoc_pkg::EDGE_PS_BITS-1:0] riseAdvancePs,
  output logic riseAligned,
  output logic [aoc_pkg::EDGE_PS_BITS-1:0] fallAdvancePs,
  output logic fallAligned,
  output logic digitalPathEnable,
  output logic quickSleep,
  output logic fullPowerdown,
  output logic swingOverride,
  output logic highFreqTuning,
  output logic diffClockDrive,
  output logic diffDataDrive
);
  import aoc_pkg::*;

  // only the 14-bit and 12-bit variants exist
  if (OUT_BITS != 14 && OUT_BITS != 12)
  begin : g_bad_width
    $error("OUT_BITS must be 14 or 12");
  end

  typedef struct packed {
    aoc_ser_state_type serState;
    logic serClkPrev;
    logic [3:0] bitCnt;
    logic [7:0] addr;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic serDataOut;
    logic [REG_COUNT-1:0][7:0] regs;
    logic signed [ACC_BITS-1:0] acc;
    logic [OUT_BITS-1:0] dataOut;
    logic outputDriveEnable;
    logic lvdsMode;
    logic [1:0] cmosClockDrive;
    logic [EDGE_PS_BITS-1:0] riseAdvancePs;
    logic riseAligned;
    logic [EDGE_PS_BITS-1:0] fallAdvancePs;
    logic fallAligned;
    logic digitalPathEnable;
    logic quickSleep;
    logic fullPowerdown;
    logic swingOverride;
    logic highFreqTuning;
    logic diffClockDrive;
    logic diffDataDrive;
  } aoc_state_type;

  aoc_state_type q;
  aoc_state_type d;

  // address decode: {hit, index}
  function automatic logic [4:0] regFind(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < REG_COUNT; i++)
    begin
      if (REG_OFFSETS[i] == a)
        r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  // edge advance {aligned, ps} from code and interface kind
  function automatic logic [EDGE_PS_BITS:0] edgeAdj(input logic [1:0] code,
    input logic lvds, input logic rise);
    logic [EDGE_PS_BITS:0] r;
    r = '0;
    case (code)
      2'h1: r[EDGE_PS_BITS-1:0] = !lvds ? CMOS_EDGE_01_PS :
        (rise ? LVDS_RISE_01_PS : LVDS_FALL_01_PS);
      2'h2:
      begin
        if (lvds)
          r[EDGE_PS_BITS] = 1'b1;
        else
          r[EDGE_PS_BITS-1:0] = CMOS_EDGE_10_PS;
      end
      2'h3: r[EDGE_PS_BITS-1:0] = !lvds ? CMOS_EDGE_11_PS :
        (rise ? LVDS_RISE_11_PS : LVDS_FALL_11_PS);
      default: r = '0;
    endcase
    return r;
  endfunction

  logic sclkRise;
  logic wrStb;
  logic [7:0] wrData;
  logic [4:0] wrFind;
  logic [4:0] rdFind;
  logic [7:0] newAddr;
  logic [1:0] fmt;
  logic digEn;
  logic corrEn;
  logic hold;
  logic [3:0] tcCode;
  logic signed [ACC_BITS-1:0] accShifted;
  logic signed [15:0] estimate;
  logic signed [15:0] corrected;
  logic signed [15:0] target;
  logic signed [15:0] loopErr;
  logic [SAMPLE_BITS-1:0] correctedWord;
  logic [SAMPLE_BITS-1:0] customWord;
  logic [SAMPLE_BITS-1:0] word;
  logic [SAMPLE_BITS-1:0] fmtWord;
  logic twos;
  logic lvdsNow;
  logic [EDGE_PS_BITS:0] riseEdge;
  logic [EDGE_PS_BITS:0] fallEdge;

  // serial port, register writes, correction loop and output stage
  always_comb
  begin
    d = q;
    wrStb = 1'b0;
    newAddr = {q.shiftIn[6:0], serDataIn};
    wrData = {q.shiftIn[6:0], serDataIn};
    wrFind = regFind(q.addr);
    rdFind = regFind(newAddr);
    sclkRise = serClk & ~q.serClkPrev;
    d.serClkPrev = serClk;
    // a frame is 8 address bits then 8 data bits, msb first
    if (serEnableN)
    begin
      d.serState = SER_IDLE;
      d.bitCnt = 4'h0;
    end
    else if (sclkRise)
    begin
      case (q.serState)
        SER_IDLE, SER_ADDR:
        begin
          d.shiftIn = newAddr;
          d.bitCnt = q.bitCnt + 4'h1;
          d.serState = SER_ADDR;
          if (q.bitCnt == SER_LAST_BIT)
          begin
            d.addr = newAddr;
            d.bitCnt = 4'h0;
            d.serState = SER_DATA;
            // unmapped addresses read back as zero
            d.shiftOut = rdFind[4] ? q.regs[rdFind[3:0]] : 8'h00;
          end
        end
        SER_DATA:
        begin
          d.shiftIn = wrData;
          d.shiftOut = {q.shiftOut[6:0], 1'b0};
          d.bitCnt = q.bitCnt + 4'h1;
          if (q.bitCnt == SER_LAST_BIT)
          begin
            // a readout frame never writes; unmapped writes are dropped
            wrStb = !readoutEnable && wrFind[4];
            d.serState = SER_DONE;
          end
        end
        SER_DONE: d.serState = SER_DONE;
        default: d.serState = SER_IDLE;
      endcase
    end
    d.serDataOut = readoutEnable & d.shiftOut[7];
    // reserved bits are masked so a careless host cannot set them
    for (int i = 0; i < REG_COUNT; i++)
    begin
      if (wrStb && wrFind[3:0] == 4'(i))
        d.regs[i] = wrData & REG_MASKS[i];
    end

    // decoded fields, all from the stored registers
    fmt = q.regs[IDX_FORMAT][FMT_LSB+:2];
    digEn = q.regs[IDX_FALL][DIG_EN_BIT];
    corrEn = digEn & q.regs[IDX_FORMAT][LOOP_EN_BIT];
    hold = q.regs[IDX_LOOP][HOLD_BIT];
    tcCode = q.regs[IDX_LOOP][TC_LSB+:4];
    // codes above 1011 clamp to the slowest loop
    if (tcCode > TC_MAX_CODE)
      tcCode = TC_MAX_CODE;
    // estimate is the integrated error divided by 2^(20+code)
    accShifted = q.acc >>> (TC_BASE_SHIFT + int'(tcCode));
    estimate = accShifted[15:0];
    corrected = $signed({2'b00, sampleIn}) - estimate;
    if (corrected < 16'sh0000)
      correctedWord = '0;
    else if (corrected > 16'sh3fff)
      correctedWord = '1;
    else
      correctedWord = corrected[SAMPLE_BITS-1:0];
    // settle point: mid-code plus the signed six-bit pedestal
    target = MID_CODE + 16'($signed(q.regs[IDX_PED][PED_LSB+:6]));
    loopErr = $signed({2'b00, correctedWord}) - target;
    if (!corrEn)
      d.acc = '0;
    else if (!hold)
      d.acc = q.acc + ACC_BITS'(loopErr);
    // hold leaves acc alone, so the last estimate keeps being subtracted

    customWord = {q.regs[IDX_PAT_HI], q.regs[IDX_PAT_LO][PAT_LO_LSB+:6]};
    // low-latency mode passes the raw sample on to the format coding untouched
    if (!digEn)
      word = sampleIn;
    else if (testPatternSelect == PATTERN_CUSTOM)
      word = customWord;
    else if (corrEn)
      word = correctedWord;
    else
      word = sampleIn;
    // code 01 is undefined; it follows the pin like 00
    twos = (fmt == FMT_TWOS) || (!fmt[1] && formatSelectPin);
    fmtWord = word;
    if (twos)
      fmtWord[SAMPLE_BITS-1] = ~word[SAMPLE_BITS-1];
    // narrow variant keeps the top bits of the word
    d.dataOut = fmtWord[SAMPLE_BITS-1 -: OUT_BITS];

    // interface: 00 and 10 follow the pin
    case (q.regs[IDX_IFACE][IFACE_LSB+:2])
      IFACE_LVDS: lvdsNow = 1'b1;
      IFACE_CMOS: lvdsNow = 1'b0;
      default: lvdsNow = interfaceSelectPin;
    endcase
    d.lvdsMode = lvdsNow;
    d.cmosClockDrive = q.regs[IDX_IFACE][CLK_DRIVE_LSB+:2];
    // edge codes are ignored until their enable bit is set
    riseEdge = '0;
    fallEdge = '0;
    if (q.regs[IDX_IFACE][RISE_EN_BIT])
      riseEdge = edgeAdj(q.regs[IDX_IFACE][RISE_POS_LSB+:2], lvdsNow, 1'b1);
    if (q.regs[IDX_IFACE][FALL_EN_BIT])
      fallEdge = edgeAdj(q.regs[IDX_FALL][FALL_POS_LSB+:2], lvdsNow, 1'b0);
    d.riseAligned = riseEdge[EDGE_PS_BITS];
    d.riseAdvancePs = riseEdge[EDGE_PS_BITS-1:0];
    d.fallAligned = fallEdge[EDGE_PS_BITS];
    d.fallAdvancePs = fallEdge[EDGE_PS_BITS-1:0];

    d.digitalPathEnable = digEn;
    d.quickSleep = q.regs[IDX_FALL][SLEEP_BIT];
    d.fullPowerdown = q.regs[IDX_POWER][PDN_BIT];
    // every power-down state releases the data and clock pins
    d.outputDriveEnable = !(q.regs[IDX_POWER][OBUF_BIT] || d.quickSleep
      || d.fullPowerdown);
    // 01 and 10 are forbidden codes; only 11 counts as on
    d.swingOverride = q.regs[IDX_POWER][SWING_LSB+:2] == SWING_ON;
    d.highFreqTuning = q.regs[IDX_HF][HF_BIT];
    d.diffClockDrive = q.regs[IDX_DRIVE][DCLK_BIT];
    d.diffDataDrive = q.regs[IDX_DRIVE][DDATA_BIT];
  end

  // one register stage for the whole state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
      q.serState <= SER_IDLE;
    end
    else
      q <= d;
  end

  assign serDataOut = q.serDataOut;
  assign dataOut = q.dataOut;
  assign outputDriveEnable = q.outputDriveEnable;
  assign lvdsMode = q.lvdsMode;
  assign cmosClockDrive = q.cmosClockDrive;
  assign riseAdvancePs = q.riseAdvancePs;
  assign riseAligned = q.riseAligned;
  assign fallAdvancePs = q.fallAdvancePs;
  assign fallAligned = q.fallAligned;
  assign digitalPathEnable = q.digitalPathEnable;
  assign quickSleep = q.quickSleep;
  assign fullPowerdown = q.fullPowerdown;
  assign swingOverride = q.swingOverride;
  assign highFreqTuning = q.highFreqTuning;
  assign diffClockDrive = q.diffClockDrive;
  assign diffDataDrive = q.diffDataDrive;

  // checks on the bank and the output stage
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence sRegWrite;
    wrStb;
  endsequence
  sequence sObinBypass;
    (fmt == FMT_OBIN && !digEn) [*2];
  endsequence

  a_write_lands: assert property (sRegWrite |=> q.regs[$past(wrFind[3:0])] ==
    ($past(wrData) & REG_MASKS[$past(wrFind[3:0])]))
    else $error("register write not stored");
  a_twos_msb: assert property (fmt == FMT_TWOS |=>
    dataOut[OUT_BITS-1] == !$past(word[SAMPLE_BITS-1]))
    else $error("twos complement msb wrong");
  a_custom_word: assert property (digEn && fmt == FMT_OBIN &&
    testPatternSelect == PATTERN_CUSTOM |=> dataOut == $past(customWord[SAMPLE_BITS-1 -: OUT_BITS]))
    else $error("custom word not on output");
  a_bypass_raw: assert property (sObinBypass |->
    dataOut == $past(sampleIn[SAMPLE_BITS-1 -: OUT_BITS]))
    else $error("low latency path not raw");
  a_loop_off: assert property (!corrEn |=> q.acc == '0)
    else $error("loop runs while disabled");
  a_hold_estimate: assert property (corrEn && hold |=> $stable(q.acc))
    else $error("estimate moved while held");
  a_driver_off: assert property ((q.regs[IDX_POWER][OBUF_BIT] ||
    q.regs[IDX_FALL][SLEEP_BIT]) ##1 1'b1 |-> !outputDriveEnable)
    else $error("drivers on during power down");
  a_rise_default: assert property (!q.regs[IDX_IFACE][RISE_EN_BIT] |=>
    riseAdvancePs == '0 && !riseAligned)
    else $error("rise edge moved while disabled");
  a_lvds_fall: assert property (lvdsNow && q.regs[IDX_IFACE][FALL_EN_BIT] &&
    q.regs[IDX_FALL][FALL_POS_LSB+:2] == 2'h1 |=> fallAdvancePs == 11'd400)
    else $error("lvds fall advance wrong");
  a_cmos_rise: assert property (!lvdsNow && q.regs[IDX_IFACE][RISE_EN_BIT] &&
    q.regs[IDX_IFACE][RISE_POS_LSB+:2] == 2'h3 |=> riseAdvancePs == 11'd1500)
    else $error("cmos rise advance wrong");
endmodule
`default_nettype wire

// File: verif/test_aoc_output_config.sv
// self-checking bench for the output configuration register bank
`timescale 1ns/100ps
`default_nettype none
module test_aoc_output_config;
  import aoc_pkg::*;
  logic clk_sys;
  logic rst;
  logic serEnableN;
  logic serClk;
  logic serDataIn;
  logic readoutEnable;
  logic serDataOut;
  logic formatSelectPin;
  logic interfaceSelectPin;
  logic [2:0] testPatternSelect;
  logic [SAMPLE_BITS-1:0] sampleIn;
  logic [13:0] dataOut;
  logic outputDriveEnable;
  logic lvdsMode;
  logic [1:0] cmosClockDrive;
  logic [EDGE_PS_BITS-1:0] riseAdvancePs;
  logic riseAligned;
  logic [EDGE_PS_BITS-1:0] fallAdvancePs;
  logic fallAligned;
  logic digitalPathEnable;
  logic quickSleep;
  logic fullPowerdown;
  logic swingOverride;
  logic highFreqTuning;
  logic diffClockDrive;
  logic diffDataDrive;
  int num_errors = 0;
  int n_checks = 0;
  logic [7:0] rdq;
  logic [11:0] narrowOut;
  logic [13:0] fastOut;
  logic [13:0] heldOut;

  aoc_output_config #(.OUT_BITS(14)) aoc_output_config_inst (
    .clk_sys(clk_sys), .rst(rst), .serEnableN(serEnableN), .serClk(serClk),
    .serDataIn(serDataIn), .readoutEnable(readoutEnable), .serDataOut(serDataOut),
    .formatSelectPin(formatSelectPin), .interfaceSelectPin(interfaceSelectPin),
    .testPatternSelect(testPatternSelect), .sampleIn(sampleIn), .dataOut(dataOut),
    .outputDriveEnable(outputDriveEnable), .lvdsMode(lvdsMode),
    .cmosClockDrive(cmosClockDrive), .riseAdvancePs(riseAdvancePs),
    .riseAligned(riseAligned), .fallAdvancePs(fallAdvancePs), .fallAligned(fallAligned),
    .digitalPathEnable(digitalPathEnable), .quickSleep(quickSleep),
    .fullPowerdown(fullPowerdown), .swingOverride(swingOverride),
    .highFreqTuning(highFreqTuning), .diffClockDrive(diffClockDrive),
    .diffDataDrive(diffDataDrive)
  );

  // narrow variant shares every input; only its data word is watched
  aoc_output_config #(.OUT_BITS(12)) aoc_output_config_inst_narrow (
    .clk_sys(clk_sys), .rst(rst), .serEnableN(serEnableN), .serClk(serClk),
    .serDataIn(serDataIn), .readoutEnable(readoutEnable), .serDataOut(),
    .formatSelectPin(formatSelectPin), .interfaceSelectPin(interfaceSelectPin),
    .testPatternSelect(testPatternSelect), .sampleIn(sampleIn), .dataOut(narrowOut),
    .outputDriveEnable(), .lvdsMode(), .cmosClockDrive(), .riseAdvancePs(),
    .riseAligned(), .fallAdvancePs(), .fallAligned(), .digitalPathEnable(),
    .quickSleep(), .fullPowerdown(), .swingOverride(), .highFreqTuning(),
    .diffClockDrive(), .diffDataDrive()
  );

  // free-running sample clock, 100 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one frame, address then data, msb first; serClk held one cycle per level
  // readback bits are taken while serClk is still low before each later rise
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic ro,
    output logic [7:0] q);
    logic [15:0] w;
    w = {a, d};
    q = 8'h00;
    @(negedge clk_sys);
    readoutEnable = ro;
    serEnableN = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(negedge clk_sys);
      serClk = 1'b0;
      serDataIn = w[i];
      @(negedge clk_sys);
      if (i < 8)
        q[i] = serDataOut;
      serClk = 1'b1;
    end
    @(negedge clk_sys);
    serClk = 1'b0;
    serEnableN = 1'b1;
    // write lands one edge later, outputs one more
    repeat (3) @(negedge clk_sys);
    readoutEnable = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame(a, d, 1'b0, q);
  endtask

  function automatic logic [10:0] rise_ps(input logic lv, input logic [1:0] c);
    if (lv)
      return (c == 2'h1) ? LVDS_RISE_01_PS : ((c == 2'h3) ? LVDS_RISE_11_PS : 11'd0);
    return (c == 2'h1) ? 11'd100 : ((c == 2'h2) ? 11'd200 : ((c == 2'h3) ? 11'd1500 : 11'd0));
  endfunction

  function automatic logic [10:0] fall_ps(input logic lv, input logic [1:0] c);
    if (lv)
      return (c == 2'h1) ? 11'd400 : ((c == 2'h3) ? 11'd200 : 11'd0);
    return rise_ps(1'b0, c);
  endfunction

  // watchdog sized well beyond the roughly 8000 cycles of the sequence
  initial
  begin
    #(100 * 30000);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    serEnableN = 1'b1;
    serClk = 1'b0;
    serDataIn = 1'b0;
    readoutEnable = 1'b0;
    formatSelectPin = 1'b0;
    interfaceSelectPin = 1'b0;
    testPatternSelect = 3'h0;
    sampleIn = 14'h2abc;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(16'(outputDriveEnable), 16'h0001);
    check(16'(lvdsMode), 16'h0000);
    // every register reads zero after reset, then keeps only its writable bits
    for (int r = 0; r < REG_COUNT; r++)
    begin
      frame(REG_OFFSETS[r], 8'h00, 1'b1, rdq);
      check(16'(rdq), 16'h0000);
      wr(REG_OFFSETS[r], 8'hff);
      frame(REG_OFFSETS[r], 8'h00, 1'b1, rdq);
      check(16'(rdq), 16'(REG_MASKS[r]));
      wr(REG_OFFSETS[r], 8'h00);
    end
    wr(8'h55, 8'hff);
    frame(8'h55, 8'h00, 1'b1, rdq);
    check(16'(rdq), 16'h0000);
    // a frame sent in readout mode must not write
    frame(8'h4a, 8'h01, 1'b1, rdq);
    check(16'(highFreqTuning), 16'h0000);
    // output coding, low-latency path passes the sample through with only the format coding applied
    wr(8'h3d, 8'hc0);
    check(16'(dataOut), 16'h2abc);
    wr(8'h3d, 8'h80);
    check(16'(dataOut), 16'h0abc);
    wr(8'h3d, 8'h00);
    check(16'(dataOut), 16'h2abc);
    formatSelectPin = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(16'(dataOut), 16'h0abc);
    formatSelectPin = 1'b0;
    // custom word needs the digital path; offset binary avoids recoding it
    wr(8'h3f, 8'hab);
    wr(8'h40, 8'hcc);
    wr(8'h3d, 8'hc0);
    testPatternSelect = 3'h5;
    wr(8'h42, 8'h08);
    check(16'(digitalPathEnable), 16'h0001);
    check(16'(dataOut), 16'h2af3);
    check(16'(narrowOut), 16'h0abc);
    wr(8'h42, 8'h00);
    check(16'(dataOut), 16'h2abc);
    testPatternSelect = 3'h0;
    // correction loop pulls a full-scale sample down toward mid-code
    sampleIn = 14'h3fff;
    wr(8'h42, 8'h08);
    wr(8'h3d, 8'he0);
    repeat (2000) @(negedge clk_sys);
    fastOut = dataOut;
    check(16'(fastOut < 14'h3fff), 16'h0001);
    check(16'(fastOut > 14'h2000), 16'h0001);
    // freezing keeps the last estimate, so the output stops moving
    wr(8'hcf, 8'h80);
    heldOut = dataOut;
    repeat (500) @(negedge clk_sys);
    check(16'(dataOut), 16'(heldOut));
    // loop off clears the estimate and the raw sample returns
    wr(8'h3d, 8'hc0);
    check(16'(dataOut), 16'h3fff);
    // same run with a doubled time constant corrects less
    wr(8'hcf, 8'h04);
    wr(8'h3d, 8'he0);
    repeat (2000) @(negedge clk_sys);
    check(16'(dataOut > fastOut), 16'h0001);
    wr(8'h3d, 8'h00);
    wr(8'hcf, 8'h00);
    wr(8'h42, 8'h00);
    sampleIn = 14'h2abc;
    // interface selection, pin only counts for codes 00 and 10
    for (int c = 0; c < 4; c++)
      for (int p = 0; p < 2; p++)
      begin
        interfaceSelectPin = p[0];
        wr(8'h41, 8'(c << 6));
        check(16'(lvdsMode), (c == 1) ? 16'h0001 : ((c == 3) ? 16'h0000 : 16'(p)));
      end
    interfaceSelectPin = 1'b0;
    // edge placement per mode and code, drive code rides along
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++)
      begin
        wr(8'h41, {m[0] ? 2'h1 : 2'h3, c[1:0], 1'b1, c[1:0], 1'b1});
        wr(8'h42, {c[1:0], 6'h00});
        check(16'(cmosClockDrive), 16'(c));
        check(16'(riseAdvancePs), 16'(rise_ps(m[0], c[1:0])));
        check(16'(fallAdvancePs), 16'(fall_ps(m[0], c[1:0])));
        check(16'(riseAligned), 16'(m[0] && c == 2));
        check(16'(fallAligned), 16'(m[0] && c == 2));
        wr(8'h41, {m[0] ? 2'h1 : 2'h3, 3'h0, c[1:0], 1'b0});
        check(16'(riseAdvancePs), 16'h0000);
        check(16'(fallAdvancePs) | 16'(fallAligned), 16'h0000);
      end
    wr(8'h41, 8'h00);
    wr(8'h42, 8'h00);
    // power controls and simple level bits
    wr(8'h42, 8'h04);
    check(16'({quickSleep, fullPowerdown, outputDriveEnable}), 16'h0004);
    wr(8'h42, 8'h00);
    wr(8'h43, 8'h10);
    check(16'({quickSleep, fullPowerdown, outputDriveEnable}), 16'h0000);
    wr(8'h43, 8'h40);
    check(16'({quickSleep, fullPowerdown, outputDriveEnable}), 16'h0002);
    wr(8'h43, 8'h03);
    check(16'({swingOverride, outputDriveEnable}), 16'h0003);
    wr(8'h43, 8'h00);
    check(16'({swingOverride, outputDriveEnable}), 16'h0001);
    wr(8'h4a, 8'h01);
    check(16'(highFreqTuning), 16'h0001);
    wr(8'h26, 8'h02);
    check(16'({diffClockDrive, diffDataDrive}), 16'h0002);
    wr(8'h26, 8'h01);
    check(16'({diffClockDrive, diffDataDrive}), 16'h0001);
    // a mid-run reset clears every field again
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(16'({highFreqTuning, diffDataDrive, outputDriveEnable}), 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
